// >>> logic/clock_gating_pkg.sv
`default_nettype none
package clock_gating_pkg;
	localparam int NUM_PAIRS = 6;
	localparam int SYNC_WIDTH = 9;
	localparam logic [8:0] SYNC_RESET = 9'h000;

	// Register byte offsets
	localparam logic [3:0] REG_OUTPUT_ENABLE = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;

	// Output enable register fields
	localparam int OE_PAIR_LSB = 0;
	localparam int OE_REF_BIT = 6;
	localparam logic [5:0] OE_PAIR_RESET = 6'h3f;
	localparam logic OE_REF_RESET = 1'h1;

	// Configuration register fields
	localparam int CFG_LEVEL_LSB = 0;
	localparam int CFG_WOL_BIT = 2;
	localparam int CFG_SPREAD_LSB = 3;
	localparam logic [1:0] LEVEL_RESET = 2'h0;
	localparam logic WOL_RESET = 1'h0;

	// Status register fields
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_CAPTURED_BIT = 7;
	localparam int ST_LOCKED_BIT = 8;
	localparam int ST_RUNNING_LSB = 9;
	localparam int ST_REF_RUNNING_BIT = 15;
	localparam int ST_POWER_DOWN_BIT = 16;

	// Spread modes
	localparam logic [1:0] SPREAD_OFF = 2'h0;
	localparam logic [1:0] SPREAD_QUARTER = 2'h1;
	localparam logic [1:0] SPREAD_HALF = 2'h2;

	// Target addresses chosen by the address strap
	localparam logic [6:0] TARGET_ADDR_STRAP0 = 7'h68;
	localparam logic [6:0] TARGET_ADDR_STRAP1 = 7'h6a;

	// AHB-Lite codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_RUN = 3'b010,
		ST_POWER_DOWN = 3'b100
	} power_state_t;

	typedef struct packed {
		logic wake_on_lan;
		logic [1:0] spread_mode;
		logic [1:0] disabled_level;
		logic ref_enable;
		logic [5:0] pair_enable;
	} config_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [3:0] offset;
	} bus_req_t;
endpackage : clock_gating_pkg
`default_nettype wire

// >>> logic/pin_sync.sv
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Pins
	input wire logic [WIDTH-1:0] i_pins,
	// Filtered levels
	output logic [WIDTH-1:0] o_levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_levels;

	// A change counts once the second and third stage agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_levels[i] = (stage2[i] == stage3[i]) ? stage3[i] : o_levels[i];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
			o_levels <= RESET_VAL;
		end else begin
			stage1 <= i_pins;
			stage2 <= stage1;
			stage3 <= stage2;
			o_levels <= next_levels;
		end
	end
endmodule : pin_sync
`default_nettype wire

// >>> logic/clock_output_power_gating.sv
`default_nettype none
module clock_output_power_gating (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control pins and straps
	input wire logic [5:0] i_pair_enable_n,
	input wire logic i_power_down_n,
	input wire logic i_spread_strap_high,
	input wire logic i_pll_locked,
	// Shared address strap and reference clock pin
	input wire logic i_address_strap_or_ref_clock,
	output logic o_address_strap_or_ref_clock,
	output logic o_address_strap_or_ref_clock_oe,
	// Differential pairs
	output logic [5:0] o_diff_clock_true,
	output logic [5:0] o_diff_clock_comp,
	// Latched settings
	output logic [6:0] o_target_address,
	output logic [1:0] o_spread_mode,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp
);
	localparam int NP = clock_gating_pkg::NUM_PAIRS;

	function automatic logic is_mapped(input logic [31:0] addr, input logic [2:0] size);
		is_mapped = (addr[31:4] == 28'h0000000) && (size == clock_gating_pkg::HSIZE_WORD)
			&& ((addr[3:0] == clock_gating_pkg::REG_OUTPUT_ENABLE)
			|| (addr[3:0] == clock_gating_pkg::REG_CONFIG)
			|| (addr[3:0] == clock_gating_pkg::REG_STATUS));
	endfunction : is_mapped

	// Pin synchronisers
	logic [8:0] sync_levels;
	logic [5:0] enable_n_s;
	logic power_down_n_s;
	logic address_strap_s;
	logic spread_strap_s;

	// Pull-down and pull-up levels are resolved at the pad
	pin_sync #(
		.WIDTH(clock_gating_pkg::SYNC_WIDTH),
		.RESET_VAL(clock_gating_pkg::SYNC_RESET)
	) pin_sync_inst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pins({i_spread_strap_high, i_address_strap_or_ref_clock, i_power_down_n,
			i_pair_enable_n}),
		.o_levels(sync_levels)
	);

	assign enable_n_s = sync_levels[5:0];
	assign power_down_n_s = sync_levels[6];
	assign address_strap_s = sync_levels[7];
	assign spread_strap_s = sync_levels[8];

	// Power state and strap capture
	clock_gating_pkg::power_state_t state;
	clock_gating_pkg::power_state_t next_state;
	logic captured;
	logic next_captured;
	logic capture;
	logic [6:0] next_target_address;

	always_comb begin
		next_state = state;
		unique case (state)
			clock_gating_pkg::ST_INIT: begin
				if (power_down_n_s) begin
					next_state = clock_gating_pkg::ST_RUN;
				end
			end
			clock_gating_pkg::ST_RUN: begin
				if (!power_down_n_s) begin
					next_state = clock_gating_pkg::ST_POWER_DOWN;
				end
			end
			clock_gating_pkg::ST_POWER_DOWN: begin
				if (power_down_n_s) begin
					next_state = clock_gating_pkg::ST_RUN;
				end
			end
			default: begin
				next_state = clock_gating_pkg::ST_INIT;
			end
		endcase
		capture = (state == clock_gating_pkg::ST_INIT) && power_down_n_s;
		next_captured = captured | capture;
		next_target_address = o_target_address;
		if (capture) begin
			next_target_address = address_strap_s ? clock_gating_pkg::TARGET_ADDR_STRAP1
				: clock_gating_pkg::TARGET_ADDR_STRAP0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= clock_gating_pkg::ST_INIT;
			captured <= 1'b0;
			o_target_address <= clock_gating_pkg::TARGET_ADDR_STRAP0;
		end else begin
			state <= next_state;
			captured <= next_captured;
			o_target_address <= next_target_address;
		end
	end

	// Register bus
	clock_gating_pkg::bus_req_t req;
	clock_gating_pkg::bus_req_t next_req;
	clock_gating_pkg::config_t cfg;
	clock_gating_pkg::config_t next_cfg;
	logic [31:0] next_hrdata;
	logic [31:0] status_word;
	logic [5:0] pair_gate;
	logic ref_gate;

	always_comb begin
		next_req = '0;
		if (i_hsel && i_hready && i_htrans[1] && is_mapped(i_haddr, i_hsize)) begin
			next_req.valid = 1'b1;
			next_req.write = i_hwrite;
			next_req.offset = i_haddr[3:0];
		end
		next_cfg = cfg;
		if (req.valid && req.write) begin
			if (req.offset == clock_gating_pkg::REG_OUTPUT_ENABLE) begin
				next_cfg.pair_enable = i_hwdata[clock_gating_pkg::OE_PAIR_LSB +: NP];
				next_cfg.ref_enable = i_hwdata[clock_gating_pkg::OE_REF_BIT];
			end else if (req.offset == clock_gating_pkg::REG_CONFIG) begin
				next_cfg.disabled_level = i_hwdata[clock_gating_pkg::CFG_LEVEL_LSB +: 2];
				next_cfg.wake_on_lan = i_hwdata[clock_gating_pkg::CFG_WOL_BIT];
				next_cfg.spread_mode = i_hwdata[clock_gating_pkg::CFG_SPREAD_LSB +: 2];
			end
		end
		// Strap latch outranks a write in the same cycle
		if (capture) begin
			next_cfg.spread_mode = spread_strap_s ? clock_gating_pkg::SPREAD_HALF
				: clock_gating_pkg::SPREAD_OFF;
		end
		status_word = '0;
		status_word[clock_gating_pkg::ST_ADDR_LSB +: 7] = o_target_address;
		status_word[clock_gating_pkg::ST_CAPTURED_BIT] = captured;
		status_word[clock_gating_pkg::ST_LOCKED_BIT] = i_pll_locked;
		status_word[clock_gating_pkg::ST_RUNNING_LSB +: NP] = pair_gate;
		status_word[clock_gating_pkg::ST_REF_RUNNING_BIT] = ref_gate;
		status_word[clock_gating_pkg::ST_POWER_DOWN_BIT] =
			(state == clock_gating_pkg::ST_POWER_DOWN);
		next_hrdata = '0;
		if (next_req.valid && !next_req.write) begin
			if (next_req.offset == clock_gating_pkg::REG_OUTPUT_ENABLE) begin
				next_hrdata[clock_gating_pkg::OE_PAIR_LSB +: NP] = next_cfg.pair_enable;
				next_hrdata[clock_gating_pkg::OE_REF_BIT] = next_cfg.ref_enable;
			end else if (next_req.offset == clock_gating_pkg::REG_CONFIG) begin
				next_hrdata[clock_gating_pkg::CFG_LEVEL_LSB +: 2] = next_cfg.disabled_level;
				next_hrdata[clock_gating_pkg::CFG_WOL_BIT] = next_cfg.wake_on_lan;
				next_hrdata[clock_gating_pkg::CFG_SPREAD_LSB +: 2] = next_cfg.spread_mode;
			end else begin
				next_hrdata = status_word;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			req <= '0;
			cfg.pair_enable <= clock_gating_pkg::OE_PAIR_RESET;
			cfg.ref_enable <= clock_gating_pkg::OE_REF_RESET;
			cfg.disabled_level <= clock_gating_pkg::LEVEL_RESET;
			cfg.wake_on_lan <= clock_gating_pkg::WOL_RESET;
			cfg.spread_mode <= clock_gating_pkg::SPREAD_OFF;
			o_hrdata <= '0;
			o_hreadyout <= 1'b1;
			o_hresp <= clock_gating_pkg::HRESP_OKAY;
		end else begin
			req <= next_req;
			cfg <= next_cfg;
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= clock_gating_pkg::HRESP_OKAY;
		end
	end

	assign o_spread_mode = cfg.spread_mode;

	// Output gating
	logic phase;
	logic next_phase;
	logic [5:0] pair_want;
	logic [5:0] next_pair_gate;
	logic ref_want;
	logic next_ref_gate;
	logic [5:0] next_true;
	logic [5:0] next_comp;
	logic next_ref_out;
	logic next_ref_oe;
	logic running_state;
	logic down_state;

	always_comb begin
		next_phase = ~phase;
		running_state = (state == clock_gating_pkg::ST_RUN);
		down_state = (state == clock_gating_pkg::ST_POWER_DOWN);
		pair_want = {NP{running_state & i_pll_locked}} & cfg.pair_enable & ~enable_n_s;
		ref_want = captured & ((running_state & cfg.ref_enable)
			| (down_state & cfg.wake_on_lan));
		// Gates move only after a high half so no runt pulse leaves
		next_pair_gate = phase ? pair_want : pair_gate;
		next_ref_gate = phase ? ref_want : ref_gate;
		for (int i = 0; i < NP; i++) begin
			next_true[i] = next_pair_gate[i] ? next_phase : cfg.disabled_level[1];
			next_comp[i] = next_pair_gate[i] ? ~next_phase : cfg.disabled_level[0];
		end
		next_ref_out = next_ref_gate & next_phase;
		next_ref_oe = next_captured;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase <= 1'b0;
			pair_gate <= '0;
			ref_gate <= 1'b0;
			o_diff_clock_true <= '0;
			o_diff_clock_comp <= '0;
			o_address_strap_or_ref_clock <= 1'b0;
			o_address_strap_or_ref_clock_oe <= 1'b0;
		end else begin
			phase <= next_phase;
			pair_gate <= next_pair_gate;
			ref_gate <= next_ref_gate;
			o_diff_clock_true <= next_true;
			o_diff_clock_comp <= next_comp;
			o_address_strap_or_ref_clock <= next_ref_out;
			o_address_strap_or_ref_clock_oe <= next_ref_oe;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_pd_parks_pairs: assert property (
		(state == clock_gating_pkg::ST_POWER_DOWN) [*3]
		|-> (o_diff_clock_true == {NP{cfg.disabled_level[1]}})
		&& (o_diff_clock_comp == {NP{cfg.disabled_level[0]}}))
		else $error("pairs not parked in power-down");
	a_pin_disables: assert property (enable_n_s[0] [*3]
		|-> (o_diff_clock_true[0] == cfg.disabled_level[1])
		&& (o_diff_clock_comp[0] == cfg.disabled_level[0]))
		else $error("disabled pair still toggling");
	a_strap_once: assert property (
		captured |=> captured && $stable(o_target_address))
		else $error("straps latched again");
	a_address_map: assert property ($rose(captured)
		|-> o_target_address == ($past(address_strap_s)
		? clock_gating_pkg::TARGET_ADDR_STRAP1
		: clock_gating_pkg::TARGET_ADDR_STRAP0))
		else $error("wrong target address");
	a_ref_hiz_init: assert property (
		!captured |-> !o_address_strap_or_ref_clock_oe)
		else $error("reference driven before first release");
	a_ref_wol: assert property ((down_state && !cfg.wake_on_lan) [*3]
		|-> o_address_strap_or_ref_clock_oe && !o_address_strap_or_ref_clock)
		else $error("reference not disabled in power-down");
	a_ref_wol_run: assert property ((down_state && cfg.wake_on_lan) [*3]
		|-> ##[1:2] o_address_strap_or_ref_clock)
		else $error("reference stopped under wake-on-LAN");
	a_lock_hold: assert property ((!i_pll_locked) [*3] |-> pair_gate == 6'h00)
		else $error("pair running before lock");
	a_no_runt: assert property ($changed(pair_gate) |-> $past(phase))
		else $error("gate changed mid period");
	a_pair_runs: assert property ((running_state && i_pll_locked
		&& cfg.pair_enable[0] && !enable_n_s[0]) [*3] |-> pair_gate[0])
		else $error("enabled pair not running");
	a_spread_strap: assert property ($rose(captured)
		|-> o_spread_mode == ($past(spread_strap_s)
		? clock_gating_pkg::SPREAD_HALF
		: clock_gating_pkg::SPREAD_OFF))
		else $error("spread strap not applied");

	c_all_running: cover property (pair_gate == 6'h3f);
	c_wake_on_lan: cover property (down_state && ref_gate);
	c_reenter_run: cover property (down_state ##1 running_state);
	c_strap_high: cover property ($rose(captured) && o_target_address
		== clock_gating_pkg::TARGET_ADDR_STRAP1);
endmodule : clock_output_power_gating
`default_nettype wire

// >>> verif/board_pins.sv
`default_nettype none
module board_pins (
	// Controller strap drive
	input wire logic i_strap_drive,
	input wire logic i_strap_level,
	// Device side of the shared pin
	input wire logic i_ref_value,
	input wire logic i_ref_oe,
	// Resolved pin level
	output logic o_pin_level
);
	timeunit 1ns;
	timeprecision 1ns;

	// Device drive wins, then the strap, else the internal pull-down
	always_comb begin
		if (i_ref_oe) begin
			o_pin_level = i_ref_value;
		end else if (i_strap_drive) begin
			o_pin_level = i_strap_level;
		end else begin
			o_pin_level = 1'b0;
		end
	end
endmodule : board_pins
`default_nettype wire

// >>> verif/clock_output_power_gating_tb_top.sv
`default_nettype none
module clock_output_power_gating_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic i_clk, i_rst, i_power_down_n, i_spread_strap_high, i_pll_locked;
	logic [5:0] i_pair_enable_n;
	logic pin_level, ref_val, ref_oe, strap_drive, strap_level;
	logic [5:0] q_true, q_comp;
	logic [6:0] target;
	logic [1:0] spread;
	logic i_hsel, i_hwrite, hready;
	logic [31:0] i_haddr, i_hwdata, hrdata;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	logic hresp;
	int errors, comparisons;

	clock_output_power_gating clock_output_power_gating_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_pair_enable_n(i_pair_enable_n),
		.i_power_down_n(i_power_down_n), .i_spread_strap_high(i_spread_strap_high),
		.i_pll_locked(i_pll_locked), .i_address_strap_or_ref_clock(pin_level),
		.o_address_strap_or_ref_clock(ref_val), .o_address_strap_or_ref_clock_oe(ref_oe),
		.o_diff_clock_true(q_true), .o_diff_clock_comp(q_comp), .o_target_address(target),
		.o_spread_mode(spread), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
		.i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp)
	);

	board_pins board_pins_inst (
		.i_strap_drive(strap_drive), .i_strap_level(strap_level), .i_ref_value(ref_val),
		.i_ref_oe(ref_oe), .o_pin_level(pin_level)
	);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
			output logic [31:0] rdata);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= addr;
		i_hwrite <= wr;
		i_hsize <= clock_gating_pkg::HSIZE_WORD;
		do @(posedge i_clk); while (hready !== 1'b1);
		i_htrans <= 2'h0;
		i_hsel <= 1'b0;
		i_hwdata <= wdata;
		do @(posedge i_clk); while (hready !== 1'b1);
		rdata = hrdata;
		check({31'h0, hresp}, {31'h0, clock_gating_pkg::HRESP_OKAY});
	endtask : ahb

	task automatic settle;
		repeat (12) @(posedge i_clk);
	endtask : settle

	// Running pairs toggle with comp the inverse; parked pairs show the level field
	task automatic legs(input logic [5:0] run, input logic [1:0] lvl);
		logic [5:0] t0;
		@(posedge i_clk);
		t0 = q_true;
		@(posedge i_clk);
		check({26'h0, q_true ^ t0}, {26'h0, run});
		check({26'h0, (q_true ^ q_comp) & run}, {26'h0, run});
		check({26'h0, q_true & ~run}, {26'h0, {6{lvl[1]}} & ~run});
		check({26'h0, q_comp & ~run}, {26'h0, {6{lvl[0]}} & ~run});
	endtask : legs

	task automatic ref_state(input logic oe, input logic run);
		logic v0;
		@(posedge i_clk);
		v0 = ref_val;
		@(posedge i_clk);
		check({31'h0, ref_oe}, {31'h0, oe});
		check({31'h0, ref_val ^ v0}, {31'h0, run});
		if (oe && !run) begin
			check({31'h0, ref_val}, 32'h0);
		end
	endtask : ref_state

	// Wait for the shared pin to be driven after a power-down release
	task automatic await_release;
		int n;
		n = 0;
		while (ref_oe !== 1'b1 && n < 30) begin
			@(posedge i_clk);
			n++;
		end
		check({31'h0, ref_oe}, 32'h1);
	endtask : await_release

	task automatic test_startup;
		logic [31:0] rd;
		ref_state(1'b0, 1'b0);
		legs(6'h00, 2'h0);
		strap_drive <= 1'b1;
		strap_level <= 1'b1;
		i_power_down_n <= 1'b1;
		await_release();
		strap_drive <= 1'b0;
		check({25'h0, target}, 32'h6a);
		check({30'h0, spread}, 32'h2);
		ahb(1'b0, 32'h8, 32'h0, rd);
		check(rd & 32'h1ff, 32'h1ea);
		settle();
		legs(6'h3f, 2'h0);
		ref_state(1'b1, 1'b1);
		$display("Test startup done");
	endtask : test_startup

	task automatic test_pins;
		i_pair_enable_n <= 6'h09;
		settle();
		legs(6'h36, 2'h0);
		i_pair_enable_n <= 6'h00;
		settle();
		legs(6'h3f, 2'h0);
		$display("Test pins done");
	endtask : test_pins

	task automatic test_software;
		logic [31:0] rd;
		ahb(1'b1, 32'h0, 32'h1e, rd);
		ahb(1'b1, 32'h4, 32'h0a, rd);
		ahb(1'b0, 32'h4, 32'h0, rd);
		check(rd & 32'h1f, 32'h0a);
		ahb(1'b0, 32'hc, 32'h0, rd);
		check(rd, 32'h0);
		settle();
		check({30'h0, spread}, 32'h1);
		legs(6'h1e, 2'h2);
		ref_state(1'b1, 1'b0);
		ahb(1'b1, 32'h0, 32'h7f, rd);
		$display("Test software done");
	endtask : test_software

	task automatic test_power_down;
		logic [31:0] rd;
		i_power_down_n <= 1'b0;
		settle();
		legs(6'h00, 2'h2);
		ref_state(1'b1, 1'b0);
		ahb(1'b1, 32'h4, 32'h0e, rd);
		settle();
		ref_state(1'b1, 1'b1);
		ahb(1'b0, 32'h8, 32'h0, rd);
		check({24'h0, rd[16:9]}, 32'hc0);
		legs(6'h00, 2'h2);
		// A changed strap must not be latched again
		i_spread_strap_high <= 1'b0;
		i_power_down_n <= 1'b1;
		settle();
		check({25'h0, target}, 32'h6a);
		check({30'h0, spread}, 32'h1);
		legs(6'h3f, 2'h2);
		$display("Test power down done");
	endtask : test_power_down

	task automatic test_lock;
		i_pll_locked <= 1'b0;
		settle();
		legs(6'h00, 2'h2);
		i_pll_locked <= 1'b1;
		settle();
		legs(6'h3f, 2'h2);
		$display("Test lock done");
	endtask : test_lock

	// Second reset with both straps low
	task automatic test_restrap;
		logic [31:0] rd;
		i_rst <= 1'b1;
		i_power_down_n <= 1'b0;
		i_spread_strap_high <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		ref_state(1'b0, 1'b0);
		legs(6'h00, 2'h0);
		i_power_down_n <= 1'b1;
		await_release();
		check({25'h0, target}, 32'h68);
		check({30'h0, spread}, 32'h0);
		ahb(1'b0, 32'h8, 32'h0, rd);
		check(rd & 32'h1ff, 32'h1e8);
		$display("Test restrap done");
	endtask : test_restrap

	initial begin
		repeat (3000) @(posedge i_clk);
		errors++;
		conclude();
	end

	initial begin
		i_rst = 1'b1;
		i_pair_enable_n = 6'h00;
		i_power_down_n = 1'b0;
		i_spread_strap_high = 1'b1;
		i_pll_locked = 1'b1;
		strap_drive = 1'b0;
		strap_level = 1'b0;
		i_hsel = 1'b0;
		i_haddr = 32'h0;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_hsize = 3'h2;
		i_hwdata = 32'h0;
		errors = 0;
		comparisons = 0;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		test_startup();
		test_pins();
		test_software();
		test_power_down();
		test_lock();
		test_restrap();
		conclude();
	end
endmodule : clock_output_power_gating_tb_top
`default_nettype wire
